// File: rtl/bus_ram_pkg.sv
// Constants shared by the small shared-bus RAM
package bus_ram_pkg;
  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int DEPTH = 32;
  localparam int PAGE_W = DATA_W - ADDR_W;
  localparam int SYNC_W = 2;

  // ----------------------------------------
  // Packed pin vector layout
  // ----------------------------------------
  localparam int POS_BUS = 0;
  localparam int POS_PINS = POS_BUS + DATA_W;
  localparam int POS_FS = POS_PINS + ADDR_W;
  localparam int POS_MCLK = POS_FS + 1;
  localparam int POS_WC = POS_MCLK + 1;
  localparam int POS_SC = POS_WC + 1;
  localparam int POS_ME = POS_SC + 1;
  localparam int IN_W = POS_ME + 1;

  // ----------------------------------------
  // Reset values and decode pattern
  // ----------------------------------------
  localparam logic [PAGE_W-1:0] SELECT_PAGE_DEFAULT = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  // Idle pin levels: enables and commands inactive
  localparam logic [IN_W-1:0] PINS_IDLE = 18'h2_2000;
  localparam logic [SYNC_W-1:0] RST_CLEAR = 2'h0;
  localparam logic [SYNC_W-1:0] RST_ONE = 2'h1;
endpackage

// File: rtl/small_bus_ram.sv
// Small 32-byte working RAM on a shared multiplexed address/data bus
`timescale 1ns/1ps
module small_bus_ram
  import bus_ram_pkg::*;
#(
  parameter logic [bus_ram_pkg::PAGE_W-1:0] SELECT_PAGE = bus_ram_pkg::SELECT_PAGE_DEFAULT
)
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_bank_enable_n,
  input wire logic i_select_command,
  input wire logic i_write_command,
  input wire logic i_master_clock,
  input wire logic i_fast_select_n,
  input wire logic [bus_ram_pkg::ADDR_W-1:0] i_addr_pins,
  input wire logic [bus_ram_pkg::DATA_W-1:0] i_shared_io_bus,
  output logic [bus_ram_pkg::DATA_W-1:0] o_shared_io_bus,
  output logic o_shared_io_bus_oe
);
  import bus_ram_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [SYNC_W-1:0] rst_sync_reg;
  logic rst_ok;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync_reg <= RST_CLEAR;
    else
      rst_sync_reg <= {rst_sync_reg[0], RST_ONE[0]};
  end

  assign rst_ok = rst_sync_reg[1];

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic [IN_W-1:0] filt;
    logic [ADDR_W-1:0] addr;
    logic sel;
    logic [DATA_W-1:0] out;
    logic oe;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [IN_W-1:0] pins_raw;
  logic me_n;
  logic sc;
  logic wc;
  logic mclk;
  logic fs_n;
  logic [ADDR_W-1:0] pin_addr;
  logic [DATA_W-1:0] bus_byte;
  logic pins_load;
  logic bus_load;
  logic write_go;
  logic read_go;

  assign pins_raw = {i_bank_enable_n, i_select_command, i_write_command, i_master_clock,
    i_fast_select_n, i_addr_pins, i_shared_io_bus};

  // Filtered copies; all decoding looks only at these
  assign me_n = state_reg.filt[POS_ME];
  assign sc = state_reg.filt[POS_SC];
  assign wc = state_reg.filt[POS_WC];
  assign mclk = state_reg.filt[POS_MCLK];
  assign fs_n = state_reg.filt[POS_FS];
  assign pin_addr = state_reg.filt[POS_PINS +: ADDR_W];
  assign bus_byte = state_reg.filt[POS_BUS +: DATA_W];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Both commands high is undefined, so every action below excludes it while the bank is enabled
  assign bus_load = !me_n && sc && !wc && mclk;
  // Bus address cycle wins over the pins when both apply
  assign pins_load = !fs_n && mclk && !bus_load && (me_n || !wc);
  assign write_go = !me_n && !sc && wc && mclk && (!fs_n || state_reg.sel);
  assign read_go = !me_n && !sc && !wc && !mclk && (!fs_n || state_reg.sel);

  always_comb
  begin
    state_next = state_reg;
    // Three stages; a change counts once the last two agree
    state_next.s1 = pins_raw;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.filt = (state_reg.s2 & state_reg.s3) | (state_reg.filt & (state_reg.s2 ^ state_reg.s3));
    if (bus_load)
    begin
      state_next.addr = bus_byte[ADDR_W-1:0];
      state_next.sel = (bus_byte[DATA_W-1:ADDR_W] == SELECT_PAGE);
    end
    else if (pins_load)
    begin
      state_next.addr = pin_addr;
    end
    if (write_go)
    begin
      state_next.mem[state_reg.addr] = bus_byte;
    end
    // Outputs held registered; bus released in every non-read state
    state_next.oe = read_go;
    state_next.out = read_go ? state_reg.mem[state_reg.addr] : DATA_RESET;
  end

  always_ff @(posedge i_clock or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      state_reg.s1 <= PINS_IDLE;
      state_reg.s2 <= PINS_IDLE;
      state_reg.s3 <= PINS_IDLE;
      state_reg.filt <= PINS_IDLE;
      state_reg.addr <= ADDR_RESET;
      state_reg.sel <= 1'b0;
      state_reg.out <= DATA_RESET;
      state_reg.oe <= 1'b0;
      state_reg.mem <= '0;
    end
    else
      state_reg <= state_next;
  end

  assign o_shared_io_bus = state_reg.out;
  assign o_shared_io_bus_oe = state_reg.oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Idle: neither bank enable nor fast select
  sequence s_idle;
    me_n && fs_n;
  endsequence

  // Bus address cycle followed by a plain read without fast select
  sequence s_addr_then_read;
    bus_load ##1 (!bus_load && !pins_load && !write_go) [*1] ##1 (!me_n && !sc && !wc && !mclk && fs_n);
  endsequence

  property p_idle_hold;
    @(posedge i_clock) disable iff (!rst_ok)
    s_idle |=> $stable(state_reg.addr) && $stable(state_reg.sel) && $stable(state_reg.mem) && !o_shared_io_bus_oe;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle state changed latches");

  property p_pins_load;
    @(posedge i_clock) disable iff (!rst_ok)
    (!fs_n && mclk && me_n) |=> state_reg.addr == $past(pin_addr);
  endproperty
  a_pins_load: assert property (p_pins_load) else $error("address pins not latched");

  property p_fast_read;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && !sc && !wc && !mclk && !fs_n) |=> o_shared_io_bus_oe
      && o_shared_io_bus == $past(state_reg.mem[state_reg.addr]);
  endproperty
  a_fast_read: assert property (p_fast_read) else $error("fast select read not driven");

  property p_unselected_read;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && !sc && !wc && !mclk && fs_n && !state_reg.sel) |=> !o_shared_io_bus_oe;
  endproperty
  a_unselected_read: assert property (p_unselected_read) else $error("bus driven while unselected");

  property p_write;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && !sc && wc && mclk && (!fs_n || state_reg.sel)) |=>
      state_reg.mem[$past(state_reg.addr)] == $past(bus_byte) && !o_shared_io_bus_oe;
  endproperty
  a_write: assert property (p_write) else $error("write byte not stored");

  property p_write_low_hold;
    @(posedge i_clock) disable iff (!rst_ok)
    (wc && !mclk) |=> $stable(state_reg.mem) && $stable(state_reg.addr) && $stable(state_reg.sel);
  endproperty
  a_write_low_hold: assert property (p_write_low_hold) else $error("write with clock low changed state");

  property p_bus_addr;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && sc && !wc && mclk) |=> state_reg.addr == $past(bus_byte[ADDR_W-1:0]) && $stable(state_reg.mem);
  endproperty
  a_bus_addr: assert property (p_bus_addr) else $error("bus address not latched");

  property p_select_value;
    @(posedge i_clock) disable iff (!rst_ok)
    bus_load |=> state_reg.sel == ($past(bus_byte[DATA_W-1:ADDR_W]) == SELECT_PAGE);
  endproperty
  a_select_value: assert property (p_select_value) else $error("select latch wrong");

  property p_select_low_hold;
    @(posedge i_clock) disable iff (!rst_ok)
    (sc && !mclk) |=> $stable(state_reg.mem) && $stable(state_reg.addr) && $stable(state_reg.sel)
      && !o_shared_io_bus_oe;
  endproperty
  a_select_low_hold: assert property (p_select_low_hold) else $error("select with clock low changed state");

  property p_both_high;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && sc && wc) |=> $stable(state_reg.mem) && $stable(state_reg.addr) && !o_shared_io_bus_oe;
  endproperty
  a_both_high: assert property (p_both_high) else $error("undefined command acted");

  property p_select_then_read;
    @(posedge i_clock) disable iff (!rst_ok)
    s_addr_then_read |=> o_shared_io_bus_oe == state_reg.sel;
  endproperty
  a_select_then_read: assert property (p_select_then_read) else $error("read after address cycle wrong");

  // ----------------------------------------
  // Latch and array holds, loads and reads
  // ----------------------------------------
  // Read and write conditions before the select qualifier
  sequence s_read_cond;
    !me_n && !sc && !wc && !mclk;
  endsequence

  sequence s_write_cond;
    !me_n && !sc && wc && mclk;
  endsequence

  // Latched write, one settling cycle, then a latched read of the same word
  sequence s_latched_write_read;
    (write_go && fs_n) ##1 (!bus_load && !pins_load) [*1] ##1 (read_go && fs_n);
  endsequence

  property p_read_keeps;
    @(posedge i_clock) disable iff (!rst_ok)
    s_read_cond |=> $stable(state_reg.addr) && $stable(state_reg.sel) && $stable(state_reg.mem);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read state changed latches");

  property p_write_keeps;
    @(posedge i_clock) disable iff (!rst_ok)
    s_write_cond |=> $stable(state_reg.addr) && $stable(state_reg.sel);
  endproperty
  a_write_keeps: assert property (p_write_keeps) else $error("write state moved a latch");

  property p_selected_read;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && !sc && !wc && !mclk && fs_n && state_reg.sel) |=> o_shared_io_bus_oe
      && o_shared_io_bus == $past(state_reg.mem[state_reg.addr]);
  endproperty
  a_selected_read: assert property (p_selected_read) else $error("latched read not driven");

  property p_blocked_write;
    @(posedge i_clock) disable iff (!rst_ok)
    (!me_n && !sc && wc && mclk && fs_n && !state_reg.sel) |=> $stable(state_reg.mem);
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("unselected write stored");

  property p_pins_load_bank;
    @(posedge i_clock) disable iff (!rst_ok)
    (!fs_n && mclk && !me_n && !sc && !wc) |=> state_reg.addr == $past(pin_addr) && $stable(state_reg.sel);
  endproperty
  a_pins_load_bank: assert property (p_pins_load_bank) else $error("pins not latched with bank on");

  property p_sel_only_bus;
    @(posedge i_clock) disable iff (!rst_ok)
    !bus_load |=> $stable(state_reg.sel);
  endproperty
  a_sel_only_bus: assert property (p_sel_only_bus) else $error("select latch moved outside address cycle");

  property p_addr_only_loads;
    @(posedge i_clock) disable iff (!rst_ok)
    (!bus_load && !pins_load) |=> $stable(state_reg.addr);
  endproperty
  a_addr_only_loads: assert property (p_addr_only_loads) else $error("address latch moved without a load");

  property p_mem_only_write;
    @(posedge i_clock) disable iff (!rst_ok)
    !write_go |=> $stable(state_reg.mem);
  endproperty
  a_mem_only_write: assert property (p_mem_only_write) else $error("array changed without a write");

  property p_released_zero;
    @(posedge i_clock) disable iff (!rst_ok)
    !o_shared_io_bus_oe |-> o_shared_io_bus == DATA_RESET;
  endproperty
  a_released_zero: assert property (p_released_zero) else $error("released bus byte not zero");

  property p_write_then_read;
    @(posedge i_clock) disable iff (!rst_ok)
    s_latched_write_read |=> o_shared_io_bus_oe && o_shared_io_bus == $past(bus_byte, 3);
  endproperty
  a_write_then_read: assert property (p_write_then_read) else $error("written byte not read back");

endmodule // small_bus_ram

// File: testbench/ctrl_model.sv
// Controller model that drives every pin of the shared-bus RAM except clock and reset
`timescale 1ns/1ps
module ctrl_model
  import bus_ram_pkg::*;
(
  input wire logic i_clock,
  output logic o_bank_enable_n,
  output logic o_select_command,
  output logic o_write_command,
  output logic o_master_clock,
  output logic o_fast_select_n,
  output logic [bus_ram_pkg::ADDR_W-1:0] o_addr_pins,
  output logic [bus_ram_pkg::DATA_W-1:0] o_bus
);
  logic [DATA_W-1:0] last_val;

  initial
  begin
    o_bank_enable_n = 1'b1;
    o_select_command = 1'b0;
    o_write_command = 1'b0;
    o_master_clock = 1'b0;
    o_fast_select_n = 1'b1;
    o_addr_pins = 5'h00;
    o_bus = 8'h00;
    last_val = 8'h00;
  end

  // One pin state, held long enough for the input filters to see it
  task automatic put(input logic me_n, input logic sc, input logic wc, input logic mclk, input logic fs_n,
    input logic [ADDR_W-1:0] pins, input logic drive, input logic [DATA_W-1:0] val);
    @(posedge i_clock);
    o_bank_enable_n <= me_n;
    o_select_command <= sc;
    // Write is dropped whenever select is raised
    o_write_command <= wc & ~sc;
    o_master_clock <= mclk;
    o_fast_select_n <= fs_n;
    o_addr_pins <= pins;
    // Released bus shows a changed level, never the stale byte
    if (drive)
    begin
      last_val = val;
      o_bus <= val;
    end
    else
      o_bus <= ~last_val;
    repeat (6) @(posedge i_clock);
    #1;
  endtask
endmodule // ctrl_model

// File: testbench/small_bus_ram_fast_select_bench.sv
// Self-checking bench for the shared-bus RAM
`timescale 1ns/1ps
module small_bus_ram_fast_select_bench;
  import bus_ram_pkg::*;
  localparam logic [PAGE_W-1:0] PAGE = 3'h5;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic me_n, sc, wc, mclk, fs_n, bus_oe;
  logic [ADDR_W-1:0] pins;
  logic [DATA_W-1:0] model_bus, bus_out, bus_level;
  int miscompares = 0;
  int compares = 0;

  always #10 i_clock = ~i_clock;
  assign bus_level = bus_oe ? bus_out : model_bus;

  ctrl_model ctl (.i_clock(i_clock), .o_bank_enable_n(me_n), .o_select_command(sc), .o_write_command(wc),
    .o_master_clock(mclk), .o_fast_select_n(fs_n), .o_addr_pins(pins), .o_bus(model_bus));

  small_bus_ram #(.SELECT_PAGE(PAGE)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bank_enable_n(me_n),
    .i_select_command(sc), .i_write_command(wc), .i_master_clock(mclk), .i_fast_select_n(fs_n),
    .i_addr_pins(pins), .i_shared_io_bus(bus_level), .o_shared_io_bus(bus_out), .o_shared_io_bus_oe(bus_oe));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read state, then judge both bus outputs
  task automatic rd(input logic fsn, input logic exp_oe, input logic [7:0] exp);
    ctl.put(1'b0, 1'b0, 1'b0, 1'b0, fsn, 5'h00, 1'b0, 8'h00);
    chk("oe", {7'h00, exp_oe}, {7'h00, bus_oe});
    chk("data", exp_oe ? exp : 8'h00, bus_out);
  endtask

  task automatic bus_sel(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] a);
    ctl.put(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 5'h1F, 1'b1, {pg, a});
  endtask

  task automatic wr(input logic fsn, input logic [7:0] d);
    ctl.put(1'b0, 1'b0, 1'b1, 1'b1, fsn, 5'h00, 1'b1, d);
  endtask

  task automatic t_fast;
    ctl.put(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 8'h00);
    wr(1'b0, 8'hA5);
    rd(1'b0, 1'b1, 8'hA5);
    ctl.put(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h1F, 1'b0, 8'h00);
    wr(1'b0, 8'h3C);
    rd(1'b0, 1'b1, 8'h3C);
    ctl.put(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 8'h00);
    rd(1'b0, 1'b1, 8'hA5);
    $display("test fast select done");
  endtask

  task automatic t_bus_sel;
    bus_sel(PAGE, 5'h07);
    wr(1'b1, 8'h5A);
    rd(1'b1, 1'b1, 8'h5A);
    bus_sel(PAGE ^ 3'h1, 5'h07);
    rd(1'b1, 1'b0, 8'h00);
    wr(1'b1, 8'hFF);
    bus_sel(PAGE, 5'h07);
    rd(1'b1, 1'b1, 8'h5A);
    $display("test bus select done");
  endtask

  task automatic t_holds;
    ctl.put(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h03, 1'b1, 8'h11);
    ctl.put(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h03, 1'b1, {PAGE ^ 3'h1, 5'h02});
    ctl.put(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 5'h03, 1'b1, 8'h22);
    ctl.put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 5'h03, 1'b1, {PAGE ^ 3'h2, 5'h04});
    rd(1'b1, 1'b1, 8'h5A);
    // Write then read in the next half cycle at the same latched word
    wr(1'b1, 8'hC3);
    rd(1'b1, 1'b1, 8'hC3);
    $display("test holds done");
  endtask

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #100000;
    miscompares++;
    $display("BAD watchdog expected end seen hang");
    wrap_up();
  end

  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    chk("oe", 8'h00, {7'h00, bus_oe});
    chk("data", 8'h00, bus_out);
    t_fast();
    t_bus_sel();
    t_holds();
    wrap_up();
  end
endmodule // small_bus_ram_fast_select_bench
